/* File: src/fieldbus_io_assembly_map_regs.svh */
/*
 holds the service codes, instance numbers, bit positions, masks, answer codes and reset values
 of the assembly bank as macros.
 assumes it is included by its bare name wherever these numbers are used.
*/
`ifndef FIELDBUS_IO_ASSEMBLY_MAP_REGS_SVH
`define FIELDBUS_IO_ASSEMBLY_MAP_REGS_SVH

`define INSTANCE_COUNT 8
`define ATTR_DATA 8'h03
`define SVC_GET 8'h0e
`define SVC_SET 8'h10
`define SVC_RELEASE 8'h4c

`define INST_BASIC_CMD 8'h03
`define INST_DUAL_CMD 8'h04
`define INST_DUAL_RST_CMD 8'h05
`define INST_BASIC_STAT 8'h34
`define INST_EXT_STAT 8'h35
`define INST_FULL_STAT 8'h36
`define INST_MASTER_CTRL 8'h64
`define INST_FAULT_STAT 8'h65

`define BIT_RUN1 0
`define BIT_RUN2 1
`define BIT_RESET 2
`define BIT_STOP 3
`define BIT_LOCK 5
`define BIT_FAULT 0
`define BIT_WARN 1
`define BIT_RUNNING1 2
`define BIT_RUNNING2 3
`define BIT_NETCTL 5
`define BIT_AUX1 6
`define BIT_AUX2 7

`define MASK_BASIC_CMD 8'h05
`define MASK_DUAL_CMD 8'h03
`define MASK_DUAL_RST_CMD 8'h07
`define MASK_MASTER_CTRL 8'h2f

`define ST_OK 8'h00
`define ST_SVC_UNSUP 8'h08
`define ST_STATE_CONFLICT 8'h0c
`define ST_NOT_SETTABLE 8'h0e
`define ST_ATTR_UNSUP 8'h14
`define ST_NO_OBJECT 8'h16
`define ST_NOT_GETTABLE 8'h2c

`define RESET_BYTE 8'h00

`endif

/* File: src/fieldbus_io_pkg.sv */
/*
 holds the types shared by the assembly bank and its service decoder.
 assumes nothing of its surroundings.
*/
package fieldbus_io_pkg;

   typedef enum logic [3:0] {
      inst_basic_cmd = 4'h0,
      inst_dual_cmd = 4'h1,
      inst_dual_rst_cmd = 4'h2,
      inst_basic_stat = 4'h3,
      inst_ext_stat = 4'h4,
      inst_full_stat = 4'h5,
      inst_master_ctrl = 4'h6,
      inst_fault_stat = 4'h7,
      inst_none = 4'hf
   } inst_type;

   typedef struct packed {
      logic lock;
      logic stop;
      logic reset;
      logic run2;
      logic run1;
   } cmd_type;

endpackage

/* File: src/svc_decode_if.sv */
/*
 carries an addressed instance number to the service decoder and its decoded class back.
 assumes one clock domain; the signals are combinational.
*/
`timescale 1ns/1ps
interface svc_decode_if;
   logic [7:0] instance_num;
   fieldbus_io_pkg::inst_type inst;
   logic readable;
   logic writable;

   modport decoder (
      input instance_num,
      output inst,
      output readable,
      output writable
   );
   modport user (
      output instance_num,
      input inst,
      input readable,
      input writable
   );
endinterface

/* File: src/service_decoder.sv */
/*
 maps an instance number onto one of the eight assembly instances and says whether it is
 gettable or settable.
 assumes the instance number is stable for the cycle in which it is looked at.
*/
`timescale 1ns/1ps
`include "fieldbus_io_assembly_map_regs.svh"
module service_decoder (
   svc_decode_if.decoder bus
);

   // *****************************************
   // instance lookup
   // *****************************************
   always_comb begin
      bus.inst = fieldbus_io_pkg::inst_none;
      bus.readable = 1'b0;
      bus.writable = 1'b0;
      case (bus.instance_num)
         `INST_BASIC_CMD: begin
            bus.inst = fieldbus_io_pkg::inst_basic_cmd;
            bus.writable = 1'b1;
         end
         `INST_DUAL_CMD: begin
            bus.inst = fieldbus_io_pkg::inst_dual_cmd;
            bus.writable = 1'b1;
         end
         `INST_DUAL_RST_CMD: begin
            bus.inst = fieldbus_io_pkg::inst_dual_rst_cmd;
            bus.writable = 1'b1;
         end
         `INST_BASIC_STAT: begin
            bus.inst = fieldbus_io_pkg::inst_basic_stat;
            bus.readable = 1'b1;
         end
         `INST_EXT_STAT: begin
            bus.inst = fieldbus_io_pkg::inst_ext_stat;
            bus.readable = 1'b1;
         end
         `INST_FULL_STAT: begin
            bus.inst = fieldbus_io_pkg::inst_full_stat;
            bus.readable = 1'b1;
         end
         `INST_MASTER_CTRL: begin
            bus.inst = fieldbus_io_pkg::inst_master_ctrl;
            bus.writable = 1'b1;
         end
         `INST_FAULT_STAT: begin
            bus.inst = fieldbus_io_pkg::inst_fault_stat;
            bus.readable = 1'b1;
         end
         default: begin
            bus.inst = fieldbus_io_pkg::inst_none;
         end
      endcase
   end

endmodule

/* File: src/fieldbus_io_assembly_map.sv */
/*
 bank of eight byte-wide assembly instances answering get, set and release services, taking
 poll command bytes, and producing the status byte for change-of-state and cyclic transfers.
 assumes one 25 MHz clock; status levels come from logic on that clock, switch and feedback
 inputs come from pins, and the connection object pulses conn_alloc_in on allocation.
*/
// Functional notes
// [RULE1] eight addressable one-byte assembly instances
// [RULE2] only attribute three is served
// [RULE3] get returns current instance contents
// [RULE4] set loads byte into writable instance
// [RULE5] release tears down present connections
// [RULE6] instance three: start one, trip reset
// [RULE7] instance four: start one, start two
// [RULE8] instance five: both starts and reset
// [RULE9] instance 52: fault and running one
// [RULE10] instance 53 adds warning, network control
// [RULE11] instance 54 adds running two, feedbacks
// [RULE12] instance 100: starts, reset, stop, lock
// [RULE13] lock under admin drops to user mode
// [RULE14] instance 101 reports fault and status byte
// [RULE15] network commands need network control switch
// [RULE16] cyclic and change transfers send instance 54
// [RULE17] poll carries one instance 100 byte
// [RULE18] reserved bits read zero, writes ignored
// [RULE19] command bits held until next write
`timescale 1ns/1ps
`include "fieldbus_io_assembly_map_regs.svh"
module fieldbus_io_assembly_map (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic req_valid_in,
   input wire logic [7:0] req_service_in,
   input wire logic [7:0] req_instance_in,
   input wire logic [7:0] req_attribute_in,
   input wire logic [7:0] req_data_in,
   output logic rsp_valid_out,
   output logic [7:0] rsp_status_out,
   output logic [7:0] rsp_data_out,
   input wire logic poll_valid_in,
   input wire logic [7:0] poll_cmd_in,
   output logic poll_ack_out,
   input wire logic cyclic_tick_in,
   output logic cos_valid_out,
   output logic [7:0] io_status_out,
   input wire logic conn_alloc_in,
   output logic connections_active_out,
   output logic conn_release_out,
   input wire logic fault_in,
   input wire logic warning_in,
   input wire logic running1_in,
   input wire logic running2_in,
   input wire logic [7:0] fault_status_in,
   input wire logic net_ctrl_switch_in,
   input wire logic aux_sense1_in,
   input wire logic aux_sense2_in,
   input wire logic admin_mode_in,
   output logic run1_cmd_out,
   output logic run2_cmd_out,
   output logic trip_reset_cmd_out,
   output logic stop_cmd_out,
   output logic settings_lock_request_out,
   output logic settings_write_enable_out,
   output logic user_mode_out,
   output logic config_display_out
);

   // *****************************************
   // declarations
   // *****************************************
   logic [2:0] pin_meta_r;
   logic [2:0] pin_sync_r;
   logic net_ok;
   logic [7:0] stat_basic;
   logic [7:0] stat_ext;
   logic [7:0] stat_full;
   logic [7:0] read_byte;
   logic [7:0] status_nxt;
   logic set_accept;
   logic poll_accept;
   logic release_hit;
   fieldbus_io_pkg::cmd_type cmd_r;
   fieldbus_io_pkg::cmd_type cmd_nxt;
   logic [7:0] io_status_r;
   svc_decode_if dec_bus ();

   // *****************************************
   // helpers
   // *****************************************
   // keeps only the bits the addressed output instance defines
   function automatic fieldbus_io_pkg::cmd_type decode_cmd(
      input fieldbus_io_pkg::inst_type inst,
      input logic [7:0] data
   );
      logic [7:0] mask;
      logic [7:0] kept;
      fieldbus_io_pkg::cmd_type res;
      mask = 8'h00;
      case (inst)
         fieldbus_io_pkg::inst_basic_cmd: mask = `MASK_BASIC_CMD; // [RULE6]
         fieldbus_io_pkg::inst_dual_cmd: mask = `MASK_DUAL_CMD; // [RULE7]
         fieldbus_io_pkg::inst_dual_rst_cmd: mask = `MASK_DUAL_RST_CMD; // [RULE8]
         fieldbus_io_pkg::inst_master_ctrl: mask = `MASK_MASTER_CTRL; // [RULE12]
         default: mask = 8'h00;
      endcase
      kept = data & mask; // [RULE18]
      res.run1 = kept[`BIT_RUN1];
      res.run2 = kept[`BIT_RUN2];
      res.reset = kept[`BIT_RESET];
      res.stop = kept[`BIT_STOP];
      res.lock = kept[`BIT_LOCK];
      return res;
   endfunction

   // *****************************************
   // pin synchronisers
   // *****************************************
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_meta_r <= 3'h0;
         pin_sync_r <= 3'h0;
      end else begin
         pin_meta_r <= {aux_sense2_in, aux_sense1_in, net_ctrl_switch_in};
         pin_sync_r <= pin_meta_r;
      end
   end

   assign net_ok = pin_sync_r[0];

   // *****************************************
   // input instances
   // *****************************************
   always_comb begin
      stat_basic = 8'h00; // [RULE18]
      stat_basic[`BIT_FAULT] = fault_in; // [RULE9]
      stat_basic[`BIT_RUNNING1] = running1_in;
      stat_ext = stat_basic; // [RULE10]
      stat_ext[`BIT_WARN] = warning_in;
      stat_ext[`BIT_NETCTL] = net_ok;
      stat_full = stat_basic; // [RULE11]
      stat_full[`BIT_RUNNING2] = running2_in;
      stat_full[`BIT_NETCTL] = net_ok;
      stat_full[`BIT_AUX1] = pin_sync_r[1];
      stat_full[`BIT_AUX2] = pin_sync_r[2];
   end

   // *****************************************
   // service decode
   // *****************************************
   assign dec_bus.instance_num = req_instance_in;

   service_decoder i_service_decoder (
      .bus(dec_bus.decoder)
   );

   always_comb begin
      case (dec_bus.inst) // [RULE1]
         fieldbus_io_pkg::inst_basic_stat: read_byte = stat_basic;
         fieldbus_io_pkg::inst_ext_stat: read_byte = stat_ext;
         fieldbus_io_pkg::inst_full_stat: read_byte = stat_full;
         fieldbus_io_pkg::inst_fault_stat: read_byte = fault_status_in; // [RULE14]
         default: read_byte = 8'h00;
      endcase
   end

   always_comb begin
      status_nxt = `ST_SVC_UNSUP;
      set_accept = 1'b0;
      release_hit = 1'b0;
      case (req_service_in)
         `SVC_GET: begin
            if (dec_bus.inst == fieldbus_io_pkg::inst_none) begin
               status_nxt = `ST_NO_OBJECT;
            end else if (req_attribute_in != `ATTR_DATA) begin // [RULE2]
               status_nxt = `ST_ATTR_UNSUP;
            end else if (!dec_bus.readable) begin // [RULE6]
               status_nxt = `ST_NOT_GETTABLE;
            end else begin
               status_nxt = `ST_OK; // [RULE3]
            end
         end
         `SVC_SET: begin
            if (dec_bus.inst == fieldbus_io_pkg::inst_none) begin
               status_nxt = `ST_NO_OBJECT;
            end else if (req_attribute_in != `ATTR_DATA) begin // [RULE2]
               status_nxt = `ST_ATTR_UNSUP;
            end else if (!dec_bus.writable) begin // [RULE9]
               status_nxt = `ST_NOT_SETTABLE;
            end else if (!net_ok) begin // [RULE15]
               status_nxt = `ST_STATE_CONFLICT;
            end else begin
               status_nxt = `ST_OK; // [RULE4]
               set_accept = req_valid_in;
            end
         end
         `SVC_RELEASE: begin
            status_nxt = `ST_OK;
            release_hit = req_valid_in; // [RULE5]
         end
         default: begin
            status_nxt = `ST_SVC_UNSUP;
         end
      endcase
   end

   // *****************************************
   // explicit answer
   // *****************************************
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rsp_valid_out <= 1'b0;
         rsp_status_out <= `ST_OK;
         rsp_data_out <= `RESET_BYTE;
      end else begin
         rsp_valid_out <= req_valid_in;
         if (req_valid_in) begin
            rsp_status_out <= status_nxt;
            if (req_service_in == `SVC_GET && status_nxt == `ST_OK) begin
               rsp_data_out <= read_byte; // [RULE3]
            end else begin
               rsp_data_out <= `RESET_BYTE;
            end
         end
      end
   end

   // *****************************************
   // command levels
   // *****************************************
   assign poll_accept = poll_valid_in && net_ok; // [RULE15] [RULE17]

   always_comb begin
      cmd_nxt = cmd_r; // [RULE19]
      if (set_accept) begin
         cmd_nxt = decode_cmd(dec_bus.inst, req_data_in); // [RULE4]
      end else if (poll_accept) begin
         cmd_nxt = decode_cmd(fieldbus_io_pkg::inst_master_ctrl, poll_cmd_in); // [RULE17]
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cmd_r <= '0;
         poll_ack_out <= 1'b0;
      end else begin
         cmd_r <= cmd_nxt; // [RULE19]
         poll_ack_out <= poll_accept;
      end
   end

   assign run1_cmd_out = cmd_r.run1;
   assign run2_cmd_out = cmd_r.run2;
   assign trip_reset_cmd_out = cmd_r.reset;
   assign stop_cmd_out = cmd_r.stop;
   assign settings_lock_request_out = cmd_r.lock;

   // *****************************************
   // settings access
   // *****************************************
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         settings_write_enable_out <= 1'b0;
         user_mode_out <= 1'b0;
         config_display_out <= 1'b0;
      end else begin
         settings_write_enable_out <= admin_mode_in && !cmd_nxt.lock; // [RULE13]
         user_mode_out <= admin_mode_in && cmd_nxt.lock;
         config_display_out <= admin_mode_in;
      end
   end

   // *****************************************
   // connections
   // *****************************************
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         connections_active_out <= 1'b0;
         conn_release_out <= 1'b0;
      end else begin
         conn_release_out <= release_hit && connections_active_out; // [RULE5]
         if (conn_alloc_in) begin
            connections_active_out <= 1'b1;
         end else if (release_hit) begin
            connections_active_out <= 1'b0;
         end
      end
   end

   // *****************************************
   // change-of-state and cyclic status
   // *****************************************
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         io_status_r <= `RESET_BYTE;
         cos_valid_out <= 1'b0;
      end else begin
         io_status_r <= stat_full; // [RULE16]
         cos_valid_out <= cyclic_tick_in || (stat_full != io_status_r);
      end
   end

   assign io_status_out = io_status_r;

   // *****************************************
   // checks
   // *****************************************
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!arst_n_in);

   chk_answer_next_cycle: assert property ( // [RULE3]
      req_valid_in && req_service_in == `SVC_GET && req_instance_in == `INST_FULL_STAT
      && req_attribute_in == `ATTR_DATA |=> rsp_valid_out && rsp_status_out == `ST_OK
      && rsp_data_out == $past(stat_full))
      else $error("get of status instance answered wrongly");

   chk_attr_refused: assert property ( // [RULE2]
      req_valid_in && req_service_in == `SVC_SET && req_attribute_in != `ATTR_DATA && !poll_accept
      |=> rsp_status_out != `ST_OK && $stable(cmd_r))
      else $error("set on wrong attribute took effect");

   chk_set_control: assert property ( // [RULE12]
      req_valid_in && req_service_in == `SVC_SET && req_instance_in == `INST_MASTER_CTRL
      && req_attribute_in == `ATTR_DATA && net_ok
      |=> stop_cmd_out == $past(req_data_in[`BIT_STOP])
      && settings_lock_request_out == $past(req_data_in[`BIT_LOCK])
      && run1_cmd_out == $past(req_data_in[`BIT_RUN1]))
      else $error("control byte not loaded");

   chk_release_drop: assert property ( // [RULE5]
      release_hit && !conn_alloc_in |=> !connections_active_out)
      else $error("release left connections active");

   chk_wo_unreadable: assert property ( // [RULE6]
      req_valid_in && req_service_in == `SVC_GET && req_instance_in == `INST_BASIC_CMD
      && req_attribute_in == `ATTR_DATA |=> rsp_status_out == `ST_NOT_GETTABLE)
      else $error("output instance was readable");

   chk_ro_unwritable: assert property ( // [RULE9]
      req_valid_in && req_service_in == `SVC_SET && req_instance_in == `INST_BASIC_STAT
      && !poll_valid_in |=> rsp_status_out != `ST_OK && $stable(cmd_r))
      else $error("input instance was writable");

   chk_dual_no_reset: assert property ( // [RULE7]
      set_accept && dec_bus.inst == fieldbus_io_pkg::inst_dual_cmd
      |=> !trip_reset_cmd_out && !stop_cmd_out)
      else $error("dual start instance set a reset");

   chk_net_gate: assert property ( // [RULE15]
      !net_ok |=> $stable(cmd_r))
      else $error("command taken without network control");

   chk_level_hold: assert property ( // [RULE19]
      !set_accept && !poll_accept [*2] |=> $stable(cmd_r))
      else $error("command level changed without a write");

   chk_reserved_zero: assert property ( // [RULE18]
      io_status_r[4] == 1'b0 && io_status_r[1] == 1'b0)
      else $error("reserved status bit set");

   chk_lock_user: assert property ( // [RULE13]
      admin_mode_in && cmd_nxt.lock |=> user_mode_out && config_display_out
      && !settings_write_enable_out)
      else $error("lock did not drop to user mode");

   chk_cos_on_change: assert property ( // [RULE16]
      $changed(io_status_r) |-> cos_valid_out)
      else $error("status change not announced");

endmodule

/* File: verification/devicenet_master_model.sv */
/*
 behavioural fieldbus master: issues explicit get, set and release requests and poll bytes.
 assumes one clock; it drives at the falling edge and reads the answer one cycle later.
*/
`timescale 1ns/1ps
`include "fieldbus_io_assembly_map_regs.svh"
module devicenet_master_model (
   input wire logic clock_in,
   output logic req_valid_out,
   output logic [7:0] req_service_out,
   output logic [7:0] req_instance_out,
   output logic [7:0] req_attribute_out,
   output logic [7:0] req_data_out,
   output logic poll_valid_out,
   output logic [7:0] poll_cmd_out,
   input wire logic rsp_valid_in,
   input wire logic [7:0] rsp_status_in,
   input wire logic [7:0] rsp_data_in,
   input wire logic poll_ack_in
);
   initial begin
      req_valid_out = 1'h0;
      poll_valid_out = 1'h0;
      {req_service_out, req_instance_out, req_attribute_out, req_data_out, poll_cmd_out} = 40'h0;
   end

   // released request lines show the inverse so stale values cannot pass
   task automatic service(input logic [7:0] svc, inst, attr, data, output logic [7:0] st, dat,
                          output logic seen);
      @(negedge clock_in);
      req_valid_out = 1'h1;
      {req_service_out, req_instance_out, req_attribute_out, req_data_out} = {svc, inst, attr, data};
      @(negedge clock_in);
      seen = rsp_valid_in;
      st = rsp_status_in;
      dat = rsp_data_in;
      req_valid_out = 1'h0;
      {req_service_out, req_instance_out, req_attribute_out, req_data_out} = ~{svc, inst, attr, data};
   endtask

   // one command byte per poll, laid out as the control byte
   task automatic poll(input logic [7:0] cmd, output logic ack);
      @(negedge clock_in);
      poll_valid_out = 1'h1;
      poll_cmd_out = cmd;
      @(negedge clock_in);
      ack = poll_ack_in;
      poll_valid_out = 1'h0;
      poll_cmd_out = ~cmd;
   endtask
endmodule

/* File: verification/test_fieldbus_io_assembly_map.sv */
/*
 self-checking bench for the assembly bank, one task per scenario.
 assumes the design sources and the master model are compiled before it.
*/
`timescale 1ns/1ps
`include "fieldbus_io_assembly_map_regs.svh"
module test_fieldbus_io_assembly_map;
   logic clock_in, arst_n_in, req_valid_in, poll_valid_in, cyclic_tick_in, conn_alloc_in;
   logic [7:0] req_service_in, req_instance_in, req_attribute_in, req_data_in, poll_cmd_in, fault_status_in;
   logic fault_in, warning_in, running1_in, running2_in, net_ctrl_switch_in, aux_sense1_in, aux_sense2_in;
   logic admin_mode_in, rsp_valid_out, poll_ack_out, cos_valid_out, connections_active_out, conn_release_out;
   logic [7:0] rsp_status_out, rsp_data_out, io_status_out, cmd_levels, st, dat;
   logic run1_cmd_out, run2_cmd_out, trip_reset_cmd_out, stop_cmd_out, settings_lock_request_out;
   logic settings_write_enable_out, user_mode_out, config_display_out, seen;
   int errors = 0;
   int tests_run = 0;

   assign cmd_levels = {3'h0, settings_lock_request_out, stop_cmd_out, trip_reset_cmd_out, run2_cmd_out,
                        run1_cmd_out};

   fieldbus_io_assembly_map i_fieldbus_io_assembly_map (.clock_in, .arst_n_in, .req_valid_in, .req_service_in,
      .req_instance_in, .req_attribute_in, .req_data_in, .rsp_valid_out, .rsp_status_out, .rsp_data_out,
      .poll_valid_in, .poll_cmd_in, .poll_ack_out, .cyclic_tick_in, .cos_valid_out, .io_status_out,
      .conn_alloc_in, .connections_active_out, .conn_release_out, .fault_in, .warning_in, .running1_in,
      .running2_in, .fault_status_in, .net_ctrl_switch_in, .aux_sense1_in, .aux_sense2_in, .admin_mode_in,
      .run1_cmd_out, .run2_cmd_out, .trip_reset_cmd_out, .stop_cmd_out, .settings_lock_request_out,
      .settings_write_enable_out, .user_mode_out, .config_display_out);

   devicenet_master_model i_devicenet_master_model (.clock_in, .req_valid_out(req_valid_in),
      .req_service_out(req_service_in), .req_instance_out(req_instance_in),
      .req_attribute_out(req_attribute_in), .req_data_out(req_data_in), .poll_valid_out(poll_valid_in),
      .poll_cmd_out(poll_cmd_in), .rsp_valid_in(rsp_valid_out), .rsp_status_in(rsp_status_out),
      .rsp_data_in(rsp_data_out), .poll_ack_in(poll_ack_out));

   // ****************************************
   // shared helpers
   // ****************************************
   initial begin
      clock_in = 1'h0;
      forever #20 clock_in = ~clock_in;
   end

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: bit %b, expected %b", $time, got, exp);
      end
   endtask

   task automatic svc(input logic [7:0] code, inst, attr, data, exp_st, exp_dat);
      i_devicenet_master_model.service(code, inst, attr, data, st, dat, seen);
      cmp_bit(seen, 1'h1);
      cmp_byte(st, exp_st);
      cmp_byte(dat, exp_dat);
   endtask

   // order: net control, aux2, aux1, running2, running1, warning, fault
   task automatic set_status(input logic [6:0] s);
      {net_ctrl_switch_in, aux_sense2_in, aux_sense1_in, running2_in, running1_in, warning_in, fault_in} = s;
      repeat (4) @(negedge clock_in);
   endtask

   task automatic stop_test;
      if (errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic check_commands;
      logic [7:0] insts [4] = '{`INST_BASIC_CMD, `INST_DUAL_CMD, `INST_DUAL_RST_CMD, `INST_MASTER_CTRL};
      logic [7:0] exp [4] = '{8'h05, 8'h03, 8'h07, 8'h1f};
      set_status(7'h40);
      for (int i = 0; i < 4; i++) begin
         svc(`SVC_SET, insts[i], `ATTR_DATA, 8'hff, `ST_OK, 8'h00);
         cmp_byte(cmd_levels, exp[i]);
         svc(`SVC_GET, insts[i], `ATTR_DATA, 8'h00, `ST_NOT_GETTABLE, 8'h00);
      end
   endtask

   task automatic check_status;
      logic [6:0] pats [2] = '{7'h7f, 7'h1a};
      logic [6:0] s;
      logic [7:0] e54;
      for (int i = 0; i < 2; i++) begin
         s = pats[i];
         fault_status_in = (i == 0) ? 8'ha5 : 8'h3c;
         set_status(s);
         e54 = {s[5], s[4], s[6], 1'h0, s[3], s[2], 1'h0, s[0]};
         svc(`SVC_GET, `INST_BASIC_STAT, `ATTR_DATA, 8'h00, `ST_OK, {5'h0, s[2], 1'h0, s[0]});
         svc(`SVC_GET, `INST_EXT_STAT, `ATTR_DATA, 8'h00, `ST_OK, {2'h0, s[6], 2'h0, s[2:0]});
         svc(`SVC_GET, `INST_FULL_STAT, `ATTR_DATA, 8'h00, `ST_OK, e54);
         cmp_byte(io_status_out, e54);
         svc(`SVC_GET, `INST_FAULT_STAT, `ATTR_DATA, 8'h00, `ST_OK, fault_status_in);
      end
      svc(`SVC_SET, `INST_BASIC_STAT, `ATTR_DATA, 8'hff, `ST_NOT_SETTABLE, 8'h00);
      svc(`SVC_SET, `INST_FAULT_STAT, `ATTR_DATA, 8'hff, `ST_NOT_SETTABLE, 8'h00);
   endtask

   task automatic check_refusals;
      svc(`SVC_GET, `INST_FULL_STAT, 8'h04, 8'h00, `ST_ATTR_UNSUP, 8'h00);
      svc(`SVC_GET, 8'h07, `ATTR_DATA, 8'h00, `ST_NO_OBJECT, 8'h00);
      svc(8'h01, `INST_FULL_STAT, `ATTR_DATA, 8'h00, `ST_SVC_UNSUP, 8'h00);
      set_status(7'h40);
      svc(`SVC_SET, `INST_MASTER_CTRL, `ATTR_DATA, 8'h0b, `ST_OK, 8'h00);
      svc(`SVC_SET, `INST_MASTER_CTRL, 8'h04, 8'hff, `ST_ATTR_UNSUP, 8'h00);
      cmp_byte(cmd_levels, 8'h0b);
      set_status(7'h00);
      svc(`SVC_SET, `INST_MASTER_CTRL, `ATTR_DATA, 8'h00, `ST_STATE_CONFLICT, 8'h00);
      i_devicenet_master_model.poll(8'h04, seen);
      cmp_bit(seen, 1'h0);
      cmp_byte(cmd_levels, 8'h0b);
   endtask

   task automatic check_poll_and_lock;
      set_status(7'h40);
      i_devicenet_master_model.poll(8'h0a, seen);
      cmp_bit(seen, 1'h1);
      cmp_byte(cmd_levels, 8'h0a);
      svc(`SVC_SET, `INST_MASTER_CTRL, `ATTR_DATA, 8'h24, `ST_OK, 8'h00);
      cmp_byte(cmd_levels, 8'h14);
      admin_mode_in = 1'h1;
      svc(`SVC_SET, `INST_MASTER_CTRL, `ATTR_DATA, 8'h20, `ST_OK, 8'h00);
      cmp_bit(user_mode_out, 1'h1);
      cmp_bit(settings_write_enable_out, 1'h0);
      cmp_bit(config_display_out, 1'h1);
      svc(`SVC_SET, `INST_MASTER_CTRL, `ATTR_DATA, 8'h00, `ST_OK, 8'h00);
      cmp_bit(user_mode_out, 1'h0);
      cmp_bit(settings_write_enable_out, 1'h1);
      admin_mode_in = 1'h0;
   endtask

   task automatic check_release;
      @(negedge clock_in);
      conn_alloc_in = 1'h1;
      @(negedge clock_in);
      conn_alloc_in = 1'h0;
      cmp_bit(connections_active_out, 1'h1);
      svc(`SVC_RELEASE, 8'h00, 8'h00, 8'h00, `ST_OK, 8'h00);
      cmp_bit(conn_release_out, 1'h1);
      cmp_bit(connections_active_out, 1'h0);
      svc(`SVC_RELEASE, 8'h00, 8'h00, 8'h00, `ST_OK, 8'h00);
      cmp_bit(conn_release_out, 1'h0);
   endtask

   task automatic check_cyclic;
      @(negedge clock_in);
      cyclic_tick_in = 1'h1;
      @(negedge clock_in);
      cyclic_tick_in = 1'h0;
      cmp_bit(cos_valid_out, 1'h1);
      fault_in = 1'h1;
      @(negedge clock_in);
      cmp_bit(cos_valid_out, 1'h1);
      cmp_byte(io_status_out, 8'h21);
      @(negedge clock_in);
      cmp_bit(cos_valid_out, 1'h0);
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      arst_n_in = 1'h0;
      {cyclic_tick_in, conn_alloc_in, admin_mode_in} = 3'h0;
      fault_status_in = 8'h00;
      set_status(7'h00);
      @(negedge clock_in);
      arst_n_in = 1'h1;
      @(negedge clock_in);
      cmp_bit(rsp_valid_out, 1'h0);
      cmp_byte(rsp_status_out, 8'h00);
      cmp_byte(cmd_levels, 8'h00);
      check_commands();
      check_status();
      check_refusals();
      check_poll_and_lock();
      check_release();
      check_cyclic();
      stop_test();
   end

   initial begin
      #200000;
      errors++;
      stop_test();
   end
endmodule
